// [hdl/gpio_fall_pull.sv]
// GPIO async falling-edge detect, event status, interrupt, pull control and function slots.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module gpio_fall_pull #(
	parameter int PINS = gpio_pkg::NUM_PINS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	input wire logic pad_por,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata_q,
	// Pins
	input wire logic [PINS-1:0] pin_in,
	// Pad pulls and function slots
	output logic [PINS-1:0] pull_up_q,
	output logic [PINS-1:0] pull_down_q,
	output logic [PINS*3-1:0] alt_slot_q,
	// Interrupt
	output logic irq_q
);
	////////////////////////////////////////////////////////////////////////////
	logic [31:0] fall_en_lo_q;
	logic [21:0] fall_en_hi_q;
	gpio_pkg::pull_sel_t pull_ctl_q;
	logic [31:0] pull_clk_lo_q;
	logic [21:0] pull_clk_hi_q;
	logic [PINS-1:0] evt_q;
	logic [PINS-1:0] mask_q;
	logic [PINS-1:0] fall_en;
	logic [PINS-1:0] tog_sync1_q;
	logic [PINS-1:0] tog_sync2_q;
	logic [PINS-1:0] tog_sync3_q;
	logic [PINS-1:0] fall_evt;
	logic [PINS-1:0] evt_clr;
	logic [PINS-1:0] tog_raw;
	logic [31:0] rd_val;

	// Write hit on one register offset.
	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off, input logic w);
		wr_hit = w && (a == off);
	endfunction

	// Zero-extends an upper-bank register for readback.
	function automatic logic [31:0] hi_word(input logic [21:0] v);
		hi_word = {10'h000, v};
	endfunction

	// Packs ten slot fields of one slot register.
	function automatic logic [31:0] slot_word(input logic [PINS*3-1:0] s, input int r);
		logic [31:0] w;
		w = '0;
		for (int k = 0; k < 10; k++) begin
			if (r * 10 + k < PINS) begin
				w[k*3 +: 3] = s[(r*10+k)*3 +: 3];
			end
		end
		slot_word = w;
	endfunction

	// True when every slot field lies in the legal range.
	function automatic logic slots_ok(input logic [PINS*3-1:0] s);
		logic ok;
		ok = 1'b1;
		for (int p = 0; p < PINS; p++) begin
			if (s[p*3 +: 3] > gpio_pkg::MAX_SLOT) begin
				ok = 1'b0;
			end
		end
		slots_ok = ok;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Enable registers.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fall_en_lo_q <= gpio_pkg::RST_WORD;
		end else if (wr_hit(addr, gpio_pkg::OFF_FALL_EN_LO, wr)) begin
			fall_en_lo_q <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			fall_en_hi_q <= 22'h000000;
		end else if (wr_hit(addr, gpio_pkg::OFF_FALL_EN_HI, wr)) begin
			fall_en_hi_q <= wdata[21:0];
		end
	end

	assign fall_en = {fall_en_hi_q, fall_en_lo_q};

	////////////////////////////////////////////////////////////////////////////
	// Pull control and pull clock registers.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pull_ctl_q <= gpio_pkg::PULL_OFF;
		end else if (wr_hit(addr, gpio_pkg::OFF_PULL_CTL, wr)) begin
			pull_ctl_q <= gpio_pkg::pull_sel_t'(wdata[1:0]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pull_clk_lo_q <= gpio_pkg::RST_WORD;
		end else if (wr_hit(addr, gpio_pkg::OFF_PULL_CLK_LO, wr)) begin
			pull_clk_lo_q <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pull_clk_hi_q <= 22'h000000;
		end else if (wr_hit(addr, gpio_pkg::OFF_PULL_CLK_HI, wr)) begin
			pull_clk_hi_q <= wdata[21:0];
		end
	end

	// One shared pull line and one pad clock per pin; the pads keep their own state.
	gpio_pad_pull #(
		.PINS(PINS)
	) u_pads (
		.core_clk(core_clk),
		.pad_por(pad_por),
		.pull_line(pull_ctl_q),
		.pad_clk({pull_clk_hi_q, pull_clk_lo_q}),
		.pull_up_q(pull_up_q),
		.pull_down_q(pull_down_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// Asynchronous falling-edge capture: each enabled falling edge toggles a flop
	// clocked by the pin itself, so pulses shorter than a core clock are not lost.
	for (genvar gi = 0; gi < PINS; gi++) begin : g_fall
		logic tog_q;
		always_ff @(negedge pin_in[gi] or posedge srst) begin
			if (srst) begin
				tog_q <= 1'b0;
			end else if (fall_en[gi]) begin
				tog_q <= ~tog_q;
			end
		end
		assign tog_raw[gi] = tog_q;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tog_sync1_q <= gpio_pkg::RST_PINS;
			tog_sync2_q <= gpio_pkg::RST_PINS;
			tog_sync3_q <= gpio_pkg::RST_PINS;
		end else begin
			tog_sync1_q <= tog_raw;
			tog_sync2_q <= tog_sync1_q;
			tog_sync3_q <= tog_sync2_q;
		end
	end

	assign fall_evt = tog_sync2_q ^ tog_sync3_q;

	////////////////////////////////////////////////////////////////////////////
	// Event status: sticky, write one to clear, a new event wins over the clear.
	assign evt_clr = {
		wr_hit(addr, gpio_pkg::OFF_EVT_HI, wr) ? wdata[21:0] : 22'h000000,
		wr_hit(addr, gpio_pkg::OFF_EVT_LO, wr) ? wdata : 32'h00000000
	};

	always_ff @(posedge core_clk) begin
		if (srst) begin
			evt_q <= gpio_pkg::RST_PINS;
		end else begin
			evt_q <= (evt_q & ~evt_clr) | fall_evt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			mask_q <= gpio_pkg::RST_PINS;
		end else if (wr_hit(addr, gpio_pkg::OFF_MASK_LO, wr)) begin
			mask_q[31:0] <= wdata;
		end else if (wr_hit(addr, gpio_pkg::OFF_MASK_HI, wr)) begin
			mask_q[53:32] <= wdata[21:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(evt_q & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Function slot fields; a value above the last slot leaves the field unchanged.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			alt_slot_q <= '0;
		end else if (wr && addr >= gpio_pkg::OFF_SLOT_BASE
			&& addr < gpio_pkg::OFF_SLOT_BASE + 8'h18 && addr[1:0] == 2'h0) begin
			for (int k = 0; k < 10; k++) begin
				for (int r = 0; r < 6; r++) begin
					if (addr == gpio_pkg::OFF_SLOT_BASE + 8'(r * 4) && r * 10 + k < PINS
						&& wdata[k*3 +: 3] <= gpio_pkg::MAX_SLOT) begin
						alt_slot_q[(r*10+k)*3 +: 3] <= wdata[k*3 +: 3];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux; pad pull state has no read path.
	always_comb begin
		rd_val = 32'h00000000;
		case (addr)
			gpio_pkg::OFF_FALL_EN_LO: rd_val = fall_en_lo_q;
			gpio_pkg::OFF_FALL_EN_HI: rd_val = hi_word(fall_en_hi_q);
			gpio_pkg::OFF_PULL_CTL: rd_val = {30'h00000000, pull_ctl_q};
			gpio_pkg::OFF_PULL_CLK_LO: rd_val = pull_clk_lo_q;
			gpio_pkg::OFF_PULL_CLK_HI: rd_val = hi_word(pull_clk_hi_q);
			gpio_pkg::OFF_EVT_LO: rd_val = evt_q[31:0];
			gpio_pkg::OFF_EVT_HI: rd_val = hi_word(evt_q[53:32]);
			gpio_pkg::OFF_MASK_LO: rd_val = mask_q[31:0];
			gpio_pkg::OFF_MASK_HI: rd_val = hi_word(mask_q[53:32]);
			8'h30: rd_val = slot_word(alt_slot_q, 0);
			8'h34: rd_val = slot_word(alt_slot_q, 1);
			8'h38: rd_val = slot_word(alt_slot_q, 2);
			8'h3C: rd_val = slot_word(alt_slot_q, 3);
			8'h40: rd_val = slot_word(alt_slot_q, 4);
			8'h44: rd_val = slot_word(alt_slot_q, 5);
			default: rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata_q <= 32'h00000000;
		end else if (rd) begin
			rdata_q <= rd_val;
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	AST_FALL_SETS_STATUS: assert property (@(posedge core_clk) disable iff (srst)
		(fall_evt != '0) |=> ((evt_q & $past(fall_evt)) == $past(fall_evt)))
		else $error("Falling edge did not set its status bit.");
	AST_DISABLED_NO_EVENT: assert property (@(posedge core_clk) disable iff (srst)
		(fall_en == '0 && tog_raw == tog_sync1_q && tog_sync1_q == tog_sync2_q
		&& tog_sync2_q == tog_sync3_q) ##1 (fall_en == '0)[*2] |-> fall_evt == '0)
		else $error("Status event with every enable off.");
	AST_HI_RESERVED: assert property (@(posedge core_clk) disable iff (srst)
		rd && addr == gpio_pkg::OFF_FALL_EN_HI |=> rdata_q[31:22] == 10'h000)
		else $error("Reserved upper enable bits read nonzero.");
	AST_PULL_READ: assert property (@(posedge core_clk) disable iff (srst)
		rd && addr == gpio_pkg::OFF_PULL_CTL |=> rdata_q == {30'h00000000, $past(pull_ctl_q)})
		else $error("Pull register readback wrong.");
	AST_RESET_VALUES: assert property (@(posedge core_clk) disable iff (srst)
		$fell(srst) |-> (pull_ctl_q == gpio_pkg::PULL_OFF && fall_en == '0))
		else $error("Register reset values wrong.");
	AST_PULL_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		wr_hit(addr, gpio_pkg::OFF_PULL_CTL, wr) |=> pull_ctl_q == $past(wdata[1:0]))
		else $error("Pull line did not follow the written value.");
	AST_SLOTS_LEGAL: assert property (@(posedge core_clk) disable iff (srst)
		slots_ok(alt_slot_q))
		else $error("Function slot above the last slot.");
	AST_READ_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (srst)
		!rd |=> rdata_q == 32'h00000000)
		else $error("Read data outside the answer cycle.");
	AST_IRQ_FOLLOWS: assert property (@(posedge core_clk) disable iff (srst)
		((evt_q & mask_q) != '0) |=> irq_q)
		else $error("Interrupt missing for an unmasked event.");
	AST_IRQ_QUIET: assert property (@(posedge core_clk) disable iff (srst)
		((evt_q & mask_q) == '0) |=> !irq_q)
		else $error("Interrupt raised with no unmasked event.");

	// Event status bookkeeping.
	AST_STATUS_STICKY: assert property (@(posedge core_clk) disable iff (srst)
		(evt_q != '0) |=> ((($past(evt_q) & ~$past(evt_clr)) & ~evt_q) == '0))
		else $error("Status bit dropped without a clear.");
	AST_W1C_CLEARS: assert property (@(posedge core_clk) disable iff (srst)
		(evt_clr != '0 && fall_evt == '0) |=> ((evt_q & $past(evt_clr)) == '0))
		else $error("Write of one did not clear the status bit.");
	AST_SET_WINS: assert property (@(posedge core_clk) disable iff (srst)
		(evt_clr != '0 && fall_evt != '0) |=> ((evt_q & $past(fall_evt)) == $past(fall_evt)))
		else $error("Clear won over a new event in the same cycle.");
	AST_NO_SPURIOUS: assert property (@(posedge core_clk) disable iff (srst)
		(fall_evt == '0) |=> ((evt_q & ~$past(evt_q)) == '0))
		else $error("Status bit set without a captured edge.");
	AST_SYNC_SHIFT: assert property (@(posedge core_clk) disable iff (srst)
		1'b1 |=> (tog_sync3_q == $past(tog_sync2_q)))
		else $error("Edge synchroniser did not shift.");

	// Register readback.
	AST_FALL_LO_READ: assert property (@(posedge core_clk) disable iff (srst)
		rd && addr == gpio_pkg::OFF_FALL_EN_LO |=> rdata_q == $past(fall_en_lo_q))
		else $error("Lower enable readback wrong.");
	AST_FALL_HI_READ: assert property (@(posedge core_clk) disable iff (srst)
		rd && addr == gpio_pkg::OFF_FALL_EN_HI |=> rdata_q == {10'h000, $past(fall_en_hi_q)})
		else $error("Upper enable readback wrong.");
	AST_PULL_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (srst)
		rd && addr == gpio_pkg::OFF_PULL_CTL |=> rdata_q[31:2] == 30'h00000000)
		else $error("Unused pull register bits read nonzero.");
	AST_CLK_HI_RESERVED: assert property (@(posedge core_clk) disable iff (srst)
		rd && addr == gpio_pkg::OFF_PULL_CLK_HI |=> rdata_q[31:22] == 10'h000)
		else $error("Reserved upper pull clock bits read nonzero.");
	AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (srst)
		rd && (addr == 8'h24 || addr == 8'h28 || addr == 8'h2C) |=> rdata_q == 32'h00000000)
		else $error("Unmapped read returned data.");

	// Register writes and cover points.
	AST_FALL_LO_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		wr_hit(addr, gpio_pkg::OFF_FALL_EN_LO, wr) |=> fall_en_lo_q == $past(wdata))
		else $error("Lower enable write lost.");
	AST_FALL_HI_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		wr_hit(addr, gpio_pkg::OFF_FALL_EN_HI, wr) |=> fall_en_hi_q == $past(wdata[21:0]))
		else $error("Upper enable write lost.");
	AST_CLK_LO_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		wr_hit(addr, gpio_pkg::OFF_PULL_CLK_LO, wr) |=> pull_clk_lo_q == $past(wdata))
		else $error("Lower pull clock write lost.");
	AST_CLK_HI_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		wr_hit(addr, gpio_pkg::OFF_PULL_CLK_HI, wr) |=> pull_clk_hi_q == $past(wdata[21:0]))
		else $error("Upper pull clock write lost.");
	AST_PULL_HOLD: assert property (@(posedge core_clk) disable iff (srst)
		!wr_hit(addr, gpio_pkg::OFF_PULL_CTL, wr) |=> $stable(pull_ctl_q))
		else $error("Pull line changed without a write.");
	AST_CLK_HOLD: assert property (@(posedge core_clk) disable iff (srst)
		!wr_hit(addr, gpio_pkg::OFF_PULL_CLK_LO, wr) && !wr_hit(addr, gpio_pkg::OFF_PULL_CLK_HI, wr)
		|=> ($stable(pull_clk_lo_q) && $stable(pull_clk_hi_q)))
		else $error("Pad clock changed without a write.");
	AST_SLOT_REFUSED: assert property (@(posedge core_clk) disable iff (srst)
		wr && addr == gpio_pkg::OFF_SLOT_BASE && wdata[2:0] > gpio_pkg::MAX_SLOT
		|=> alt_slot_q[2:0] == $past(alt_slot_q[2:0]))
		else $error("Illegal function slot was taken.");
	AST_SLOT_WRITE: assert property (@(posedge core_clk) disable iff (srst)
		wr && addr == gpio_pkg::OFF_SLOT_BASE && wdata[2:0] <= gpio_pkg::MAX_SLOT
		|=> alt_slot_q[2:0] == $past(wdata[2:0]))
		else $error("Legal function slot was not taken.");
	COV_SLOT_REFUSED: cover property (@(posedge core_clk) disable iff (srst)
		wr && addr == gpio_pkg::OFF_SLOT_BASE && wdata[5:3] > gpio_pkg::MAX_SLOT);
	COV_FALL_EVENT: cover property (@(posedge core_clk) disable iff (srst)
		fall_evt != '0 ##1 evt_q != '0);
	COV_IRQ: cover property (@(posedge core_clk) disable iff (srst) $rose(irq_q));
	COV_W1C: cover property (@(posedge core_clk) disable iff (srst)
		evt_q != '0 ##1 evt_q == '0);
endmodule

// [hdl/gpio_pkg.sv]
// Constants, register map, field layouts and pad defaults for the GPIO pull and async-fall block.
// Overview of operation
// - An enabled pin's falling edge sets its event status bit; disabled pins never do.
// - Falling edges are caught by the pin itself, not by sampling with the core clock.
// - Upper enable register holds pins 32-53 in bits 21-0; bits above read zero.
// - Pull field is bits 1-0: off, down, up, reserved; upper bits read zero.
// - The pull state held in the pads cannot be read back by software.
// - Pad pull states survive core reset and power-down while registers are lost.
// - After power-up pads take default pulls: high, none or low per pin.
// - One common pull line, taken from the pull field, feeds every pad.
// - Each pull clock bit set to one drives the pad clock of its pin.
// - Only pads that see a pad clock take the new pull; others keep theirs.
// - Each pin selects one of six function slots, 0 to 5; others are refused.
package gpio_pkg;
	localparam int NUM_PINS = 54;
	localparam int LO_PINS = 32;
	localparam int HI_PINS = 22;
	localparam int ADDR_W = 8;
	localparam int SLOT_W = 3;
	localparam int SLOTS_PER_REG = 10;
	localparam int NUM_SLOT_REGS = 6;
	localparam logic [2:0] MAX_SLOT = 3'h5;
	localparam int PULL_W = 2;
	localparam int SETUP_CYCLES = 150;
	localparam int HOLD_CYCLES = 150;

	localparam logic [7:0] OFF_FALL_EN_LO = 8'h00;
	localparam logic [7:0] OFF_FALL_EN_HI = 8'h04;
	localparam logic [7:0] OFF_PULL_CTL = 8'h08;
	localparam logic [7:0] OFF_PULL_CLK_LO = 8'h0C;
	localparam logic [7:0] OFF_PULL_CLK_HI = 8'h10;
	localparam logic [7:0] OFF_EVT_LO = 8'h14;
	localparam logic [7:0] OFF_EVT_HI = 8'h18;
	localparam logic [7:0] OFF_MASK_LO = 8'h1C;
	localparam logic [7:0] OFF_MASK_HI = 8'h20;
	localparam logic [7:0] OFF_SLOT_BASE = 8'h30;

	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [53:0] RST_PINS = 54'h0;
	localparam logic [53:0] DEF_PULL_UP = 54'h3FC01C000001FF;
	localparam logic [53:0] DEF_PULL_NONE = 54'h00300030000000;

	typedef enum logic [1:0] {
		PULL_OFF = 2'h0,
		PULL_DOWN = 2'h1,
		PULL_UP = 2'h2,
		PULL_RSVD = 2'h3
	} pull_sel_t;
endpackage

// [hdl/gpio_pad_pull.sv]
// Pad pull latches for every pin, clocked from the pull clock bits.
`timescale 1ns/1ps
module gpio_pad_pull #(
	parameter int PINS = gpio_pkg::NUM_PINS
) (
	// Clock and pad power-on reset
	input wire logic core_clk,
	input wire logic pad_por,
	// Common pull line and per-pad clocks
	input wire logic [1:0] pull_line,
	input wire logic [PINS-1:0] pad_clk,
	// Pad pull drive
	output logic [PINS-1:0] pull_up_q,
	output logic [PINS-1:0] pull_down_q
);
	logic [PINS-1:0] clk_prev_q;
	logic [PINS-1:0] clk_rise;

	assign clk_rise = pad_clk & ~clk_prev_q;

	always_ff @(posedge core_clk) begin
		if (pad_por) begin
			clk_prev_q <= '0;
		end else begin
			clk_prev_q <= pad_clk;
		end
	end

	// Pad state is reset only by pad power-on, never by the core reset.
	always_ff @(posedge core_clk) begin
		if (pad_por) begin
			pull_up_q <= PINS'(gpio_pkg::DEF_PULL_UP);
			pull_down_q <= PINS'(~(gpio_pkg::DEF_PULL_UP | gpio_pkg::DEF_PULL_NONE));
		end else begin
			for (int i = 0; i < PINS; i++) begin
				if (clk_rise[i]) begin
					pull_up_q[i] <= (pull_line == gpio_pkg::PULL_UP);
					pull_down_q[i] <= (pull_line == gpio_pkg::PULL_DOWN);
				end
			end
		end
	end

	AST_PAD_LATCH: assert property (@(posedge core_clk) disable iff (pad_por)
		clk_rise[0] |=> (pull_up_q[0] == ($past(pull_line) == gpio_pkg::PULL_UP)))
		else $error("Pad did not latch the pull line on its clock edge.");
	AST_PAD_HOLD: assert property (@(posedge core_clk) disable iff (pad_por)
		(clk_rise == '0) |=> ($stable(pull_up_q) && $stable(pull_down_q)))
		else $error("Pad pull changed without a pad clock edge.");
	AST_PAD_NEVER_BOTH: assert property (@(posedge core_clk) disable iff (pad_por)
		(pull_up_q & pull_down_q) == '0)
		else $error("Pad pulls up and down at once.");
	AST_PAD_DEFAULTS: assert property (@(posedge core_clk) disable iff (pad_por)
		$fell(pad_por) |-> (pull_up_q == PINS'(gpio_pkg::DEF_PULL_UP)))
		else $error("Pad defaults missing after power-on.");
	COV_PAD_UPDATE: cover property (@(posedge core_clk) disable iff (pad_por)
		clk_rise != '0 ##1 pull_up_q != $past(pull_up_q));
endmodule

// [verification/gpio_pin_model.sv]
// Pin-side model that drives short falling pulses onto the pins.
`timescale 1ns/1ps
module gpio_pin_model (
	// Clock
	input wire logic core_clk,
	// Pulse requests, one bit per pin
	input wire logic [53:0] fall_req,
	// Pin levels
	output logic [53:0] pin_out
);
	logic [53:0] pulse_mask;
	////////////////////////////////////////////////////////////////////////////////
	// Idle pins sit high, as an external pull-up holds them.
	initial begin
		pin_out = '1;
		pulse_mask = '0;
	end
	// A requested pin drops for 1 ns between rising clock edges, well under one period.
	always @(posedge core_clk) begin
		if (|fall_req) begin
			pulse_mask = fall_req;
			#2;
			pin_out = pin_out & ~pulse_mask;
			#1;
			pin_out = pin_out | pulse_mask;
		end
	end
endmodule

// [verification/tb_gpio_fall_pull.sv]
// Self-checking testbench for the GPIO async-fall and pull control block.
`timescale 1ns/1ps
module tb_gpio_fall_pull;
	logic core_clk;
	logic srst;
	logic pad_por;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata_q;
	logic [53:0] pin_in;
	logic [53:0] pull_up_q;
	logic [53:0] pull_down_q;
	logic [161:0] alt_slot_q;
	logic irq_q;
	logic [53:0] fall_req;
	logic [53:0] exp_up;
	logic [53:0] exp_dn;
	logic [31:0] lfsr_q;
	logic [31:0] rd_note[$];
	logic rd_seen;
	logic [31:0] m_lo;
	logic [31:0] m_hi;
	logic [2:0] ev;
	int failures;
	int tests_run;
	////////////////////////////////////////////////////////////////////////////////
	gpio_fall_pull gpio_fall_pull_i (.core_clk(core_clk), .srst(srst), .pad_por(pad_por),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .pin_in(pin_in),
		.pull_up_q(pull_up_q), .pull_down_q(pull_down_q), .alt_slot_q(alt_slot_q),
		.irq_q(irq_q));
	gpio_pin_model gpio_pin_model_i (.core_clk(core_clk), .fall_req(fall_req),
		.pin_out(pin_in));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("Checks run %0d, failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(1'h0, 1'h0, 8'h00, 32'h0);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, 1'h0, a, d);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		rd_note.push_back(e);
		bus(1'h0, 1'h1, a, 32'h0);
	endtask
	task automatic next_rnd;
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
	endtask
	task automatic chk_pads;
		chk({10'h0, pull_up_q}, {10'h0, exp_up});
		chk({10'h0, pull_down_q}, {10'h0, exp_dn});
	endtask
	task automatic pull_seq(input logic [1:0] mode, input logic [31:0] c_lo, input logic [31:0] c_hi);
		logic [53:0] hit;
		hit = {c_hi[21:0], c_lo};
		wr_reg(gpio_pkg::OFF_PULL_CTL, {30'h0, mode});
		idle(gpio_pkg::SETUP_CYCLES);
		wr_reg(gpio_pkg::OFF_PULL_CLK_LO, c_lo);
		wr_reg(gpio_pkg::OFF_PULL_CLK_HI, c_hi);
		idle(gpio_pkg::HOLD_CYCLES);
		wr_reg(gpio_pkg::OFF_PULL_CTL, 32'h0);
		wr_reg(gpio_pkg::OFF_PULL_CLK_LO, 32'h0);
		wr_reg(gpio_pkg::OFF_PULL_CLK_HI, 32'h0);
		idle(2);
		exp_up = (exp_up & ~hit) | ((mode == 2'h2) ? hit : 54'h0);
		exp_dn = (exp_dn & ~hit) | ((mode == 2'h1) ? hit : 54'h0);
		chk_pads();
	endtask
	task automatic pulse_pins;
		fall_req <= '1;
		idle(1);
		fall_req <= '0;
		idle(8);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Read results are compared in the cycle after each read strobe.
	always @(posedge core_clk) begin
		if (rd_seen) begin
			chk({32'h0, rdata_q}, {32'h0, rd_note.pop_front()});
		end
		rd_seen <= rd;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		print_verdict();
	end
	initial begin
		failures = 0;
		tests_run = 0;
		rd_seen = 1'h0;
		lfsr_q = 32'h4D06;
		fall_req = '0;
		wr = 1'h0;
		rd = 1'h0;
		addr = 8'h00;
		wdata = 32'h0;
		srst = 1'h1;
		pad_por = 1'h1;
		repeat (4) @(posedge core_clk);
		srst <= 1'h0;
		pad_por <= 1'h0;
		idle(1);
		exp_up = gpio_pkg::DEF_PULL_UP;
		exp_dn = ~(gpio_pkg::DEF_PULL_UP | gpio_pkg::DEF_PULL_NONE);
		chk_pads();
		for (int k = 0; k < 9; k++) rd_reg(8'(4 * k), 32'h0);
		wr_reg(gpio_pkg::OFF_FALL_EN_HI, 32'hFFFFFFFF);
		wr_reg(gpio_pkg::OFF_PULL_CTL, 32'hFFFFFFFF);
		wr_reg(8'h2C, 32'hFFFFFFFF);
		rd_reg(gpio_pkg::OFF_FALL_EN_HI, 32'h003FFFFF);
		rd_reg(gpio_pkg::OFF_PULL_CTL, 32'h00000003);
		rd_reg(8'h2C, 32'h0);
		wr_reg(gpio_pkg::OFF_FALL_EN_LO, 32'hA5A5A5A5);
		rd_reg(gpio_pkg::OFF_FALL_EN_LO, 32'hA5A5A5A5);
		wr_reg(gpio_pkg::OFF_PULL_CTL, 32'h0);
		idle(2);
		chk_pads();
		for (int m = 0; m < 4; m++) begin
			next_rnd();
			m_lo = lfsr_q;
			next_rnd();
			pull_seq(2'(m), m_lo, lfsr_q);
		end
		srst <= 1'h1;
		idle(1);
		srst <= 1'h0;
		idle(1);
		chk_pads();
		rd_reg(gpio_pkg::OFF_FALL_EN_LO, 32'h0);
		next_rnd();
		m_lo = lfsr_q | 32'h1;
		next_rnd();
		m_hi = lfsr_q;
		wr_reg(gpio_pkg::OFF_FALL_EN_LO, m_lo);
		wr_reg(gpio_pkg::OFF_FALL_EN_HI, m_hi);
		pulse_pins();
		rd_reg(gpio_pkg::OFF_EVT_LO, m_lo);
		rd_reg(gpio_pkg::OFF_EVT_HI, {10'h0, m_hi[21:0]});
		idle(1);
		chk({63'h0, irq_q}, 64'h0);
		wr_reg(gpio_pkg::OFF_MASK_LO, 32'h1);
		idle(2);
		chk({63'h0, irq_q}, 64'h1);
		wr_reg(gpio_pkg::OFF_EVT_LO, m_lo);
		wr_reg(gpio_pkg::OFF_EVT_HI, m_hi);
		idle(2);
		chk({63'h0, irq_q}, 64'h0);
		wr_reg(gpio_pkg::OFF_FALL_EN_LO, 32'h0);
		wr_reg(gpio_pkg::OFF_FALL_EN_HI, 32'h0);
		pulse_pins();
		rd_reg(gpio_pkg::OFF_EVT_LO, 32'h0);
		rd_reg(gpio_pkg::OFF_EVT_HI, 32'h0);
		wr_reg(gpio_pkg::OFF_SLOT_BASE, 32'h00000075);
		idle(1);
		chk({55'h0, alt_slot_q[8:0]}, 64'h045);
		ev = 3'h0;
		for (int v = 0; v < 8; v++) begin
			wr_reg(8'h44, 32'(v));
			idle(1);
			if (v <= 5) ev = 3'(v);
			chk({61'h0, alt_slot_q[152:150]}, {61'h0, ev});
		end
		pad_por <= 1'h1;
		idle(1);
		pad_por <= 1'h0;
		idle(1);
		exp_up = gpio_pkg::DEF_PULL_UP;
		exp_dn = ~(gpio_pkg::DEF_PULL_UP | gpio_pkg::DEF_PULL_NONE);
		chk_pads();
		idle(4);
		print_verdict();
	end
endmodule
